// ==== jsg_core.v ====
`timescale 1ns/10ps
`include "jsg_consts.vh"
// Operation
// - jog ramps at set accel, self-starting
// - jog runs until stop, kill, hold, limit
// - new jog retargets; reversal ramps through zero
// - jog overwrites stored move velocity
// - waiting events release at jog speed
// - jog costs four, plus mode extras
// - after threshold move add ramp-type cost
// - accel feedforward gain held and applied
// - reports immediate: two letters, low byte of value, LF
// - loop output clamped to +/- output bound, none while bound is zero
// - derivative gain default twenty, bounded
// - friction offset integer, default zero
// - save command copies gains for readback
module jsg_core #(
    parameter VW = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire i_limit_hit,
    input wire signed [31:0] i_loop_out,
    input wire [31:0] i_accel_cmd,
    output wire signed [VW-1:0] o_velocity,
    output reg signed [31:0] o_dac_out,
    output wire [31:0] o_ff_term,
    output reg o_event_release,
    output wire o_jogging
);
    reg aw_have_r, w_have_r;
    reg [7:0] aw_addr_r;
    reg [31:0] w_data_r;
    reg [31:0] cfg_r, gain_arg_r, vel_r, reply_r, qcost_r, stat_err_r;
    reg [31:0] ka_r, kb_r, kd_r, kf_r;
    reg [31:0] ka_sv_r, kb_sv_r, kd_sv_r, kf_sv_r;
    reg [31:0] move_vel_r;
    reg signed [VW-1:0] jog_tgt_r;
    reg run_r, at_speed_d_r;
    wire at_speed;
    wire [63:0] ff_full;
    wire wr_go;
    wire [3:0] op;
    wire [1:0] gsel;
    wire [1:0] mode;
    reg [7:0] jog_cost;
    reg [31:0] gsel_val;
    reg [31:0] gsel_sv;
    reg gain_ok;

    // upper-limit lookup for gain ranges
    function [31:0] gain_limit;
        input [1:0] sel;
        begin
            case (sel)
                `JSG_G_KB: gain_limit = `JSG_KB_MAX;
                `JSG_G_KF: gain_limit = `JSG_KF_MAX;
                default: gain_limit = `JSG_GAIN_MAX;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // axi-lite write: address and data in either order
    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    assign op = w_data_r[3:0];
    assign gsel = w_data_r[7:6];
    assign mode = cfg_r[`JSG_CFG_MODE_LO+1:`JSG_CFG_MODE_LO];

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // writes to offsets other than cmd, cfg, gain, vel answer slverr; refused commands answer okay
                case (aw_addr_r)
                    `JSG_OFS_CMD: s_axi_bresp <= 2'b00;
                    `JSG_OFS_CFG, `JSG_OFS_GAIN, `JSG_OFS_VEL:
                        s_axi_bresp <= 2'b00;
                    default: s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // queue cost of a jog, by mode flags and prior move type
    always @* begin
        jog_cost = `JSG_Q_JOG;
        if (cfg_r[`JSG_CFG_PWRAUTO])
            jog_cost = jog_cost + `JSG_Q_ONE;
        if (cfg_r[`JSG_CFG_ENCSERVO])
            jog_cost = jog_cost + `JSG_Q_ONE;
        if (cfg_r[`JSG_CFG_THRMOVE]) begin
            case (cfg_r[`JSG_CFG_RAMP_LO+1:`JSG_CFG_RAMP_LO])
                `JSG_RAMP_LIN: jog_cost = jog_cost + `JSG_Q_LIN;
                `JSG_RAMP_PAR: jog_cost = jog_cost + `JSG_Q_PAR;
                `JSG_RAMP_SC: jog_cost = jog_cost + `JSG_Q_SC;
                default: jog_cost = jog_cost;
            endcase
        end
        gain_ok = (mode == `JSG_MODE_SINGLE) &&
            (gain_arg_r <= gain_limit(gsel));
        // the output bound is open at both ends: zero and the max refuse
        if (gsel == `JSG_G_KB &&
            (gain_arg_r == 32'h0000_0000 || gain_arg_r == `JSG_KB_MAX))
            gain_ok = 1'b0;
        case (gsel)
            `JSG_G_KA: gsel_val = ka_r;
            `JSG_G_KB: gsel_val = kb_r;
            `JSG_G_KD: gsel_val = kd_r;
            default: gsel_val = kf_r;
        endcase
        // saved copy of the selected gain, for readback
        case (gsel)
            `JSG_G_KA: gsel_sv = ka_sv_r;
            `JSG_G_KB: gsel_sv = kb_sv_r;
            `JSG_G_KD: gsel_sv = kd_sv_r;
            default: gsel_sv = kf_sv_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // register file and command execution
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= 32'h0000_0000;
            gain_arg_r <= 32'h0000_0000;
            vel_r <= 32'h0000_0000;
            reply_r <= 32'h0000_0000;
            qcost_r <= 32'h0000_0000;
            stat_err_r <= 32'h0000_0000;
            ka_r <= `JSG_KA_DEF;
            kb_r <= `JSG_KB_DEF;
            kd_r <= `JSG_KD_DEF;
            kf_r <= `JSG_KF_DEF;
            ka_sv_r <= `JSG_KA_DEF;
            kb_sv_r <= `JSG_KB_DEF;
            kd_sv_r <= `JSG_KD_DEF;
            kf_sv_r <= `JSG_KF_DEF;
            move_vel_r <= 32'h0000_0000;
            jog_tgt_r <= {VW{1'b0}};
            run_r <= 1'b0;
        end else begin
            // limit only ends the jog while checking is enabled
            if (run_r && i_limit_hit && cfg_r[`JSG_CFG_LIMEN])
                run_r <= 1'b0;
            if (wr_go) begin
                case (aw_addr_r)
                    `JSG_OFS_CFG: cfg_r <= w_data_r;
                    `JSG_OFS_GAIN: gain_arg_r <= w_data_r;
                    `JSG_OFS_VEL: vel_r <= w_data_r;
                    `JSG_OFS_CMD: begin
                        stat_err_r <= 32'h0000_0000;
                        case (op)
                            `JSG_OP_JOG: begin
                                if (mode == `JSG_MODE_CONTOUR) begin
                                    stat_err_r <= 32'h0000_0001;
                                end else begin
                                    // host keeps velocity in range
                                    jog_tgt_r <= vel_r[VW-1:0];
                                    move_vel_r <= vel_r;
                                    run_r <= 1'b1;
                                    qcost_r <= {24'h00_0000, jog_cost};
                                end
                            end
                            `JSG_OP_STOP, `JSG_OP_STOP_ALL,
                            `JSG_OP_KILL, `JSG_OP_HOLD_OFF:
                                run_r <= 1'b0;
                            `JSG_OP_SET_GAIN: begin
                                if (gain_ok) begin
                                    qcost_r <= {24'h00_0000, `JSG_Q_GAIN};
                                    case (gsel)
                                        `JSG_G_KA: ka_r <= gain_arg_r;
                                        `JSG_G_KB: kb_r <= gain_arg_r;
                                        `JSG_G_KD: kd_r <= gain_arg_r;
                                        default: kf_r <= gain_arg_r;
                                    endcase
                                end else begin
                                    stat_err_r <= 32'h0000_0001;
                                end
                            end
                            `JSG_OP_REPORT: // immediate, no queue
                                reply_r <= {`JSG_ASC_K,
                                    (gsel == `JSG_G_KA) ? `JSG_ASC_A :
                                    (gsel == `JSG_G_KB) ? `JSG_ASC_B :
                                    (gsel == `JSG_G_KD) ? `JSG_ASC_D :
                                    `JSG_ASC_F,
                                    gsel_val[7:0], `JSG_LF};
                            `JSG_OP_SAVE: begin
                                ka_sv_r <= ka_r;
                                kb_sv_r <= kb_r;
                                kd_sv_r <= kd_r;
                                kf_sv_r <= kf_r;
                            end
                            default: stat_err_r <= 32'h0000_0001;
                        endcase
                    end
                    default: stat_err_r <= stat_err_r;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi-lite read, one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `JSG_OFS_CMD: s_axi_rdata <= move_vel_r;
                `JSG_OFS_CFG: s_axi_rdata <= cfg_r;
                `JSG_OFS_GAIN: s_axi_rdata <= gsel_val;
                `JSG_OFS_STAT: s_axi_rdata <= {29'h0000_0000,
                    stat_err_r[0], at_speed, run_r};
                `JSG_OFS_VEL: s_axi_rdata <= o_velocity;
                `JSG_OFS_REPLY: s_axi_rdata <= reply_r;
                `JSG_OFS_QCOST: s_axi_rdata <= qcost_r;
                `JSG_OFS_SAVED: s_axi_rdata <= gsel_sv;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // velocity ramp; kill zeroes at once
    jsg_ramp #(.VW(VW)) u_ramp (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(run_r),
        .i_target(jog_tgt_r),
        .i_accel(i_accel_cmd),
        .i_kill(wr_go && aw_addr_r == `JSG_OFS_CMD && op == `JSG_OP_KILL),
        .o_vel(o_velocity),
        .o_at_speed(at_speed)
    );
    assign o_jogging = run_r;

    // release waiting events once target speed is first reached
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            at_speed_d_r <= 1'b0;
            o_event_release <= 1'b0;
        end else begin
            at_speed_d_r <= at_speed;
            o_event_release <= at_speed && !at_speed_d_r;
        end
    end

    // feedforward term scales the commanded acceleration; only the low
    // word leaves the block, so large gains times large rates wrap
    assign ff_full = ka_r * i_accel_cmd;
    assign o_ff_term = ff_full[31:0];

    // output bound, x100 units; zero bound means no clamp
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            o_dac_out <= 32'h0000_0000;
        else if (kb_r != 32'h0000_0000 && i_loop_out > $signed(kb_r))
            o_dac_out <= $signed(kb_r);
        else if (kb_r != 32'h0000_0000 && i_loop_out < -$signed(kb_r))
            o_dac_out <= -$signed(kb_r);
        else
            o_dac_out <= i_loop_out;
    end
endmodule // jsg_core

// ==== jsg_consts.vh ====
`ifndef JSG_CONSTS_VH
`define JSG_CONSTS_VH
// register byte offsets
`define JSG_OFS_CMD 8'h00
`define JSG_OFS_CFG 8'h04
`define JSG_OFS_GAIN 8'h08
`define JSG_OFS_STAT 8'h0C
`define JSG_OFS_VEL 8'h10
`define JSG_OFS_REPLY 8'h14
`define JSG_OFS_QCOST 8'h18
`define JSG_OFS_SAVED 8'h1C
// command opcodes, cmd register bits 3:0
`define JSG_OP_JOG 4'h1
`define JSG_OP_STOP 4'h2
`define JSG_OP_STOP_ALL 4'h3
`define JSG_OP_KILL 4'h4
`define JSG_OP_HOLD_OFF 4'h5
`define JSG_OP_SET_GAIN 4'h6
`define JSG_OP_REPORT 4'h7
`define JSG_OP_SAVE 4'h8
// gain selectors, cmd bits 7:6
`define JSG_G_KA 2'h0
`define JSG_G_KB 2'h1
`define JSG_G_KD 2'h2
`define JSG_G_KF 2'h3
// cfg fields
`define JSG_CFG_LIMEN 0
`define JSG_CFG_PWRAUTO 1
`define JSG_CFG_ENCSERVO 2
`define JSG_CFG_THRMOVE 3
`define JSG_CFG_RAMP_LO 4
`define JSG_CFG_MODE_LO 6
// ramp types
`define JSG_RAMP_LIN 2'h0
`define JSG_RAMP_PAR 2'h1
`define JSG_RAMP_SC 2'h2
// axis modes
`define JSG_MODE_SINGLE 2'h0
`define JSG_MODE_MULTI 2'h1
`define JSG_MODE_CONTOUR 2'h2
// queue costs
`define JSG_Q_JOG 8'h04
`define JSG_Q_ONE 8'h01
`define JSG_Q_LIN 8'h08
`define JSG_Q_PAR 8'h0A
`define JSG_Q_SC 8'h71
`define JSG_Q_GAIN 8'h02
// gain limits and defaults, fixed point x100 except kf
`define JSG_GAIN_MAX 32'h0031_FF9C
`define JSG_KB_MAX 32'h0000_03E8
`define JSG_KF_MAX 32'h0000_7FFF
`define JSG_KA_DEF 32'h0000_0000
`define JSG_KB_DEF 32'h0000_0000
`define JSG_KD_DEF 32'h0000_07D0
`define JSG_KF_DEF 32'h0000_0000
`define JSG_VEL_MAX 32'h000F_EE1F
// ascii
`define JSG_LF 8'h0A
`define JSG_ASC_K 8'h6B
`define JSG_ASC_A 8'h61
`define JSG_ASC_B 8'h62
`define JSG_ASC_D 8'h64
`define JSG_ASC_F 8'h66
`endif

// ==== jsg_ramp.v ====
`timescale 1ns/10ps
`include "jsg_consts.vh"
// velocity ramp: slews toward target, through zero on reversal
module jsg_ramp #(
    parameter VW = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_run,
    input wire signed [VW-1:0] i_target,
    input wire [VW-1:0] i_accel,
    input wire i_kill,
    output reg signed [VW-1:0] o_vel,
    output wire o_at_speed
);
    reg signed [VW-1:0] goal;
    reg signed [VW-1:0] diff;
    reg signed [VW-1:0] step;
    ////////////////////////////////////////////////////////////////////
    // on sign change the goal is zero first, so the axis stops then
    // backs up
    always @* begin
        goal = i_run ? i_target : {VW{1'b0}};
        if (o_vel != {VW{1'b0}} && goal != {VW{1'b0}} &&
            (o_vel[VW-1] != goal[VW-1]))
            goal = {VW{1'b0}};
        diff = goal - o_vel;
        step = $signed(i_accel);
        if (step == {VW{1'b0}})
            step = {{(VW-1){1'b0}}, 1'b1}; // zero accel would never arrive
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_vel <= {VW{1'b0}};
        end else if (i_kill) begin
            o_vel <= {VW{1'b0}}; // kill drops pulses without a ramp
        end else if (diff > step) begin
            o_vel <= o_vel + step;
        end else if (diff < -step) begin
            o_vel <= o_vel - step;
        end else begin
            o_vel <= goal;
        end
    end

    assign o_at_speed = i_run && (o_vel == i_target);
endmodule // jsg_ramp

// ==== jsg_checker.sv ====
`timescale 1ns/10ps
`include "jsg_consts.vh"
module jsg_checker #(
    parameter VW = 32
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] i_accel_cmd,
    input wire signed [VW-1:0] o_velocity,
    input wire o_event_release,
    input wire o_jogging
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
////////////////////////////////////////////////////////////////////////
// bus handshakes
sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
endsequence
a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response not on time");
a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
////////////////////////////////////////////////////////////////////////
// ramp: step never beyond the accel rate (min 1) while running
a_ramp_step: assert property (o_jogging && $past(o_jogging) |->
    ((o_velocity > $past(o_velocity)) ? o_velocity - $past(o_velocity)
    : $past(o_velocity) - o_velocity) <=
    (($past(i_accel_cmd) == 0) ? 1 : $past(i_accel_cmd)))
    else $error("velocity step exceeds accel");
a_vel_range: assert property (o_velocity <= $signed(`JSG_VEL_MAX)
    && o_velocity >= -$signed(`JSG_VEL_MAX))
    else $error("velocity out of range");
a_zero_cross: assert property (!($past(o_velocity) > 0 && o_velocity < 0)
    && !($past(o_velocity) < 0 && o_velocity > 0))
    else $error("reversal skipped zero");
a_release_steady: assert property (o_event_release |-> $stable(o_velocity))
    else $error("release before speed reached");
a_release_pulse: assert property (o_event_release |=> !o_event_release)
    else $error("release not a pulse");
endmodule // jsg_checker
bind jsg_core jsg_checker #(.VW(VW)) u_chk (.*);

// ==== jsg_host.sv ====
`timescale 1ns/10ps
// host side: single outstanding AXI4-Lite master
module jsg_host (
    input wire i_clk,
    output logic [7:0] o_awaddr,
    output logic o_awvalid,
    input wire i_awready,
    output logic [31:0] o_wdata,
    output logic o_wvalid,
    input wire i_wready,
    input wire i_bvalid,
    output logic o_bready,
    output logic [7:0] o_araddr,
    output logic o_arvalid,
    input wire i_arready,
    input wire [31:0] i_rdata,
    input wire [1:0] i_rresp,
    input wire i_rvalid,
    output logic o_rready
);
initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready} = '0;
end
////////////////////////////////////////////////////////////////////////
// each channel released at the edge it is taken
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    do begin
        @(posedge i_clk);
        if (i_awready) o_awvalid <= 1'b0;
        if (i_wready) o_wvalid <= 1'b0;
    end while (i_bvalid !== 1'b1);
    o_bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge i_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    do begin
        @(posedge i_clk);
        if (i_arready) o_arvalid <= 1'b0;
    end while (i_rvalid !== 1'b1);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
endtask
endmodule // jsg_host

// ==== tb_top.sv ====
`timescale 1ns/10ps
`include "jsg_consts.vh"
module tb_top;
logic i_clk = 0, i_rst_n = 0, lim = 0;
logic signed [31:0] loop_out = 0;
logic [31:0] acc = 4, d, st;
logic [1:0] r;
int n_fail = 0, n_tests = 0, cyc = 0;
wire [7:0] awa, ara;
wire [31:0] wd, rdat, vel, dac, ff;
wire awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, rel, jog;
wire [1:0] bresp, rresp;
always #5 i_clk = ~i_clk;
jsg_host host (.i_clk(i_clk), .o_awaddr(awa), .o_awvalid(awv),
    .i_awready(awr), .o_wdata(wd), .o_wvalid(wv), .i_wready(wr_),
    .i_bvalid(bv), .o_bready(br), .o_araddr(ara), .o_arvalid(arv),
    .i_arready(arr), .i_rdata(rdat), .i_rresp(rresp), .i_rvalid(rv),
    .o_rready(rr));
jsg_core dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .i_limit_hit(lim), .i_loop_out(loop_out),
    .i_accel_cmd(acc), .o_velocity(vel), .o_dac_out(dac),
    .o_ff_term(ff), .o_event_release(rel), .o_jogging(jog));
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
        n_fail++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// hang guard: every scenario is a few thousand cycles at most
always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
        n_fail++;
        tally_and_finish();
    end
end
// sample at the falling edge so registered outputs have settled
task automatic wait_for(input logic want_rel);
    for (int k = 0; k < 400; k++) begin
        @(negedge i_clk);
        if (want_rel ? (rel === 1'b1) : (jog === 1'b0)) break;
    end
    if (want_rel) chk({31'h0, rel}, 32'h0000_0001);
endtask
task automatic jog_to(input logic [31:0] v);
    host.wr(`JSG_OFS_VEL, v);
    host.wr(`JSG_OFS_CMD, {28'h0, `JSG_OP_JOG});
endtask
////////////////////////////////////////////////////////////////////////
task automatic t_jog_reverse;
    jog_to(32'h0000_0190);
    @(negedge i_clk) d = vel;
    @(negedge i_clk) chk(vel - d, acc);
    wait_for(1);
    chk(vel, 32'h0000_0190);
    host.rd(`JSG_OFS_CMD, d, r);
    chk(d, 32'h0000_0190);
    host.rd(`JSG_OFS_QCOST, d, r);
    chk(d, {24'h0, `JSG_Q_JOG});
    @(posedge i_clk) acc <= 32'h0000_0008;
    jog_to(32'hFFFF_FE70);
    wait_for(1);
    chk(vel, 32'hFFFF_FE70);
    chk({31'h0, jog}, 32'h0000_0001);
    chk(ff, 32'h0000_0018);
    @(posedge i_clk) acc <= 32'h0000_0004;
endtask
// every terminating command, then the limit switch
task automatic t_terminate;
    for (int op = 2; op <= 5; op++) begin
        jog_to(32'h0000_0064);
        host.wr(`JSG_OFS_CMD, op);
        wait_for(0);
        chk({31'h0, jog}, 32'h0000_0000);
    end
    // limit checking off: the switch must not end the jog
    jog_to(32'h0000_0064);
    @(posedge i_clk) lim <= 1'b1;
    repeat (4) @(negedge i_clk);
    chk({31'h0, jog}, 32'h0000_0001);
    @(posedge i_clk) lim <= 1'b0;
    host.wr(`JSG_OFS_CFG, 32'h0000_0001);
    jog_to(32'h0000_0064);
    @(posedge i_clk) lim <= 1'b1;
    wait_for(0);
    chk({31'h0, jog}, 32'h0000_0000);
    @(posedge i_clk) lim <= 1'b0;
endtask
task automatic t_queue_cost;
    logic [7:0] cfgs [5] = '{8'h02, 8'h06, 8'h08, 8'h18, 8'h28};
    logic [7:0] cost [5] = '{8'h05, 8'h06, 8'h0C, 8'h0E, 8'h75};
    for (int i = 0; i < 5; i++) begin
        host.wr(`JSG_OFS_CFG, cfgs[i]);
        jog_to(32'h0000_0064);
        host.rd(`JSG_OFS_QCOST, d, r);
        chk(d, cost[i]);
    end
    host.wr(`JSG_OFS_CFG, 32'h0000_0080);
    jog_to(32'h0000_0064);
    host.rd(`JSG_OFS_STAT, st, r);
    chk(st & 32'h4, 32'h0000_0004);
    host.wr(`JSG_OFS_CMD, {28'h0, `JSG_OP_KILL});
    host.wr(`JSG_OFS_CFG, 32'h0000_0000);
endtask
task automatic set_gain(input logic [1:0] s, input logic [31:0] v);
    host.wr(`JSG_OFS_GAIN, v);
    host.wr(`JSG_OFS_CMD, {24'h0, s, 2'h0, `JSG_OP_SET_GAIN});
endtask
task automatic report(input logic [1:0] s, input logic [31:0] exp);
    host.wr(`JSG_OFS_CMD, {24'h0, s, 2'h0, `JSG_OP_REPORT});
    host.rd(`JSG_OFS_REPLY, d, r);
    chk(d, exp);
endtask
task automatic t_gains;
    report(`JSG_G_KD, 32'h6B64_D00A);
    set_gain(`JSG_G_KB, 32'h0000_01F4);
    @(posedge i_clk) loop_out <= 32'sd800;
    repeat (3) @(negedge i_clk);
    chk(dac, 32'h0000_01F4);
    host.rd(`JSG_OFS_QCOST, d, r);
    chk(d, {24'h0, `JSG_Q_GAIN});
    set_gain(`JSG_G_KB, `JSG_KB_MAX);
    host.rd(`JSG_OFS_GAIN, d, r);
    chk(d, 32'h0000_01F4);
    set_gain(`JSG_G_KA, 32'h0000_0003);
    @(negedge i_clk);
    chk(ff, 32'h0000_000C);
    set_gain(`JSG_G_KF, `JSG_KF_MAX);
    host.rd(`JSG_OFS_GAIN, d, r);
    chk(d, `JSG_KF_MAX);
    report(`JSG_G_KF, 32'h6B66_FF0A);
    set_gain(`JSG_G_KD, `JSG_GAIN_MAX + 1);
    host.rd(`JSG_OFS_GAIN, d, r);
    chk(d, `JSG_KD_DEF);
    host.wr(`JSG_OFS_CMD, {28'h0, `JSG_OP_SAVE});
    set_gain(`JSG_G_KF, 32'h0000_0005);
    host.rd(`JSG_OFS_SAVED, d, r);
    chk(d, `JSG_KF_MAX);
    host.rd(`JSG_OFS_GAIN, d, r);
    chk(d, 32'h0000_0005);
    host.wr(`JSG_OFS_CFG, 32'h0000_0040);
    chk({30'h0, bresp}, 32'h0000_0000);
    set_gain(`JSG_G_KD, 32'h0000_0007);
    host.rd(`JSG_OFS_GAIN, d, r);
    chk(d, `JSG_KD_DEF);
    host.rd(`JSG_OFS_STAT, st, r);
    chk(st & 32'h4, 32'h0000_0004);
    host.rd(8'h20, d, r);
    chk({30'h0, r}, 32'h0000_0002);
    // status is read-only, a write to it is refused
    host.wr(`JSG_OFS_STAT, 32'h0000_0000);
    chk({30'h0, bresp}, 32'h0000_0002);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_gains();
    t_jog_reverse();
    t_terminate();
    t_queue_cost();
    tally_and_finish();
end
endmodule // tb_top
